// file: bench/dssf_asserts.sv
// checker for the status and speed feedback words at the block's ports
// assumes binding to drive_status_speed_feedback, one clock, sync reset
`timescale 1ns/10ps
module dssf_asserts
#(
  parameter FREQ_W = 16
)
(
  // clock and reset
  input logic              clk,
  input logic              rst,
  // watched inputs
  input logic              run_request,
  input logic              fault,
  input logic              forward,
  input logic              settings_conflict,
  input logic              enable_request,
  input logic [FREQ_W-1:0] actual_frequency,
  input logic [FREQ_W-1:0] rated_frequency_setting,
  input logic              reg_read,
  input logic              reg_write,
  input logic              reg_sel,
  // watched outputs
  input logic [15:0]       reg_rdata,
  input logic              reg_ack,
  input logic              stage_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // speed path is two deep, so the operands must sit still for four edges
  sequence at_rated(logic fw);
    (forward == fw && actual_frequency == rated_frequency_setting && rated_frequency_setting != 0)[*4];
  endsequence
  sequence stat_read;
    reg_read && !reg_sel && !$past(rst) && $stable(run_request) && $stable(fault);
  endsequence
  a_ack_follows: assert property ((reg_read || reg_write) |=> reg_ack) else $error("ack missing");
  a_ack_single: assert property (!(reg_read || reg_write) |=> !reg_ack) else $error("stray ack");
  a_reserved_zero: assert property (stat_read |=> reg_rdata[0] == 0 && reg_rdata[4:3] == 0 && !reg_rdata[14])
    else $error("reserved status bit set");
  a_run_fault: assert property (stat_read |=> reg_rdata[1] == $past(run_request) && reg_rdata[15] == $past(fault))
    else $error("run or fault bit wrong");
  a_stage_gate: assert property (stage_enable |-> $past(enable_request) && !$past(settings_conflict))
    else $error("stage enabled against conflict");
  a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata)) else $error("read data moved");
  a_fwd_rated: assert property (at_rated(1) ##0 (reg_read && reg_sel) |=> reg_rdata == 16'h2000)
    else $error("rated forward speed wrong");
  a_rev_rated: assert property (at_rated(0) ##0 (reg_read && reg_sel) |=> reg_rdata == 16'hE000)
    else $error("rated reverse speed wrong");
endmodule // dssf_asserts

bind drive_status_speed_feedback dssf_asserts #(.FREQ_W(FREQ_W)) dssf_asserts_i
  (.clk(clk), .rst(rst), .run_request(run_request), .fault(fault), .forward(forward),
   .settings_conflict(settings_conflict), .enable_request(enable_request), .actual_frequency(actual_frequency),
   .rated_frequency_setting(rated_frequency_setting), .reg_read(reg_read), .reg_write(reg_write),
   .reg_sel(reg_sel), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .stage_enable(stage_enable));

// file: bench/poll_master.sv
// polling network master: reads and writes the two words over the register port
// assumes the block acks each request one cycle after taking it
`timescale 1ns/10ps
module poll_master
(
  // clock
  input  logic        clk,
  // register port
  input  logic        reg_ack,
  input  logic [15:0] reg_rdata,
  output logic        reg_read,
  output logic        reg_write,
  output logic        reg_sel,
  output logic [15:0] reg_wdata
);
  initial {reg_read, reg_write, reg_sel, reg_wdata} = 19'h0;
  // request pulsed for one edge; answer taken mid-cycle so no edge race
  task xfer(input logic wr, input logic sel, input logic [15:0] wd, output logic [15:0] rd);
    int n;
    @(negedge clk);
    reg_read = !wr;
    reg_write = wr;
    reg_sel = sel;
    reg_wdata = wd;
    @(negedge clk);
    {reg_read, reg_write} = 2'h0;
    reg_wdata = ~wd; // no stale data left on the lines
    for (n = 0; n < 4 && reg_ack !== 1'b1; n++) @(negedge clk);
    rd = reg_rdata;
  endtask
endmodule // poll_master

// file: bench/tb_top.sv
// self-checking bench for the status and speed feedback words
// assumes poll_master as the far side and dssf_asserts bound to the block
`timescale 1ns/10ps
module tb_top;
  logic        clk;
  logic        rst;
  logic [11:0] f;
  logic [15:0] freq;
  logic [15:0] rated;
  logic        reg_read, reg_write, reg_sel, reg_ack, stage_enable;
  logic [15:0] reg_wdata, reg_rdata, d;
  int          err_total = 0;
  int          n_checks = 0;
  int          pos[12] = '{1, 2, 5, 6, 7, 8, 9, 10, 11, 12, 13, 15};
  logic [15:0] fq[8] = '{16'h0, 16'h3C, 16'h3C, 16'h12C, 16'h12C, 16'h7, 16'h7, 16'hF0};
  logic [15:0] ex[8] = '{16'h0, 16'h2000, 16'hE000, 16'h7FFF, 16'h8000, 16'h3BB, 16'hFC45, 16'h8000};
  logic [7:0]  fw = 8'h2B;

  drive_status_speed_feedback drive_status_speed_feedback_i
    (.clk(clk), .rst(rst), .run_request(f[0]), .override_active(f[1]), .second_ramp_select(f[2]),
     .settings_conflict(f[3]), .alarm(f[4]), .running(f[5]), .enable_request(f[6]), .forward(f[7]),
     .inching_function(f[8]), .remote(f[9]), .undervoltage(f[10]), .fault(f[11]), .actual_frequency(freq),
     .rated_frequency_setting(rated), .reg_read(reg_read), .reg_write(reg_write), .reg_sel(reg_sel),
     .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .stage_enable(stage_enable));
  poll_master poll_master_i
    (.clk(clk), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_read(reg_read), .reg_write(reg_write),
     .reg_sel(reg_sel), .reg_wdata(reg_wdata));

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // each flag alone, then all together, then a write that must not stick
  task t_status;
    for (int i = 0; i < 12; i++)
    begin
      @(negedge clk) f = 12'h1 << i;
      poll_master_i.xfer(0, 0, 16'h0, d);
      chk("status", d, 16'h1 << pos[i]);
      chk("stage", {15'h0, stage_enable}, {15'h0, i == 6});
      chk("ack", {15'h0, reg_ack}, 16'h0001);
    end
    @(negedge clk) f = 12'hFFF;
    poll_master_i.xfer(1, 0, 16'hFFFF, d);
    poll_master_i.xfer(0, 0, 16'h0, d);
    chk("status all", d, 16'hBDE6);
    chk("stage blocked", {15'h0, stage_enable}, 16'h0);
  endtask
  // rated, clamp both ways, exact -32768 and truncation toward zero
  task t_speed;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk) freq = fq[i];
      f[7] = fw[i];
      repeat (3) @(negedge clk);
      poll_master_i.xfer(0, 1, 16'h0, d);
      chk("speed", d, ex[i]);
    end
    poll_master_i.xfer(1, 1, 16'h1234, d);
    poll_master_i.xfer(0, 1, 16'h0, d);
    chk("speed after write", d, 16'h8000);
  endtask

  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    rst = 1;
    f = 12'h0;
    freq = 16'h0;
    rated = 16'h3C;
    repeat (3) @(negedge clk);
    rst = 0;
    t_status;
    t_speed;
    conclude;
  end
  initial
  begin
    #20000;
    err_total++;
    conclude;
  end
endmodule // tb_top

// file: design/drive_status_regs.vh
// constants for the inverter status word and speed feedback word
// assumes inclusion by plain Verilog-2005 design files
`ifndef DRIVE_STATUS_REGS_VH
`define DRIVE_STATUS_REGS_VH

// ********************************
// register selects
// ********************************
`define REG_SEL_STATUS           1'b0
`define REG_SEL_SPEED            1'b1

// ********************************
// status word bit positions
// ********************************
`define STAT_RUN_CMD             1
`define STAT_OVERRIDE            2
`define STAT_SECOND_RAMP         5
`define STAT_CONFIG_LOCK         6
`define STAT_ALARM               7
`define STAT_RUNNING             8
`define STAT_ENABLED             9
`define STAT_FORWARD             10
`define STAT_INCHING             11
`define STAT_REMOTE              12
`define STAT_UNDERVOLT           13
`define STAT_FAULT               15

// ********************************
// reset values and scale
// ********************************
`define STATUS_RESET             16'h0000
`define SPEED_RESET              16'h0000
`define SPEED_RATED_CODE         16'h2000
`define SPEED_RATED_SHIFT        13
`define SPEED_POS_LIMIT          16'h7FFF
`define SPEED_NEG_LIMIT          16'h8000

`endif

// file: design/drive_status_speed_feedback.v
// read-only status and speed feedback words of the inverter, seen by a polling master
// assumes state flags and frequency come from synchronous inverter logic on clk
`timescale 1ns/10ps
`include "drive_status_regs.vh"

module drive_status_speed_feedback
#(
  parameter FREQ_W = 16
)
(
  // clock and reset
  input  wire              clk,
  input  wire              rst,
  // inverter state
  input  wire              run_request,
  input  wire              override_active,
  input  wire              second_ramp_select,
  input  wire              settings_conflict,
  input  wire              alarm,
  input  wire              running,
  input  wire              enable_request,
  input  wire              forward,
  input  wire              inching_function,
  input  wire              remote,
  input  wire              undervoltage,
  input  wire              fault,
  // speed, in frequency units of the inverter
  input  wire [FREQ_W-1:0] actual_frequency,
  input  wire [FREQ_W-1:0] rated_frequency_setting,
  // register port
  input  wire              reg_read,
  input  wire              reg_write,
  input  wire              reg_sel,
  input  wire [15:0]       reg_wdata,
  output reg  [15:0]       reg_rdata,
  output reg               reg_ack,
  // power stage
  output reg               stage_enable
);

  // ********************************
  // status word
  // ********************************
  wire [15:0] status_now;
  reg  [15:0] inverter_status_word;

  // enable is refused while settings conflict
  wire enabled_now = enable_request & ~settings_conflict;

  status_packer u_status_packer
  (
    .run_request        (run_request),
    .override_active    (override_active),
    .second_ramp_select (second_ramp_select),
    .config_lock        (settings_conflict),
    .alarm              (alarm),
    .running            (running),
    .enabled            (enabled_now),
    .forward            (forward),
    .inching_function   (inching_function),
    .remote             (remote),
    .undervoltage       (undervoltage),
    .fault              (fault),
    .word               (status_now)
  );

  // ********************************
  // speed feedback word
  // ********************************
  // a new conversion every cycle; the divider latency is one cycle
  wire [15:0] speed_code;
  wire        speed_done;
  reg  [15:0] speed_feedback_word;

  speed_scaler #(.FREQ_W(FREQ_W)) u_speed_scaler
  (
    .clk     (clk),
    .rst     (rst),
    .start   (1'b1),
    .freq    (actual_frequency),
    .rated   (rated_frequency_setting),
    .reverse (~forward),
    .done    (speed_done),
    .code    (speed_code)
  );

  // ********************************
  // registers: hardware-updated, never software-written
  // ********************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      inverter_status_word <= `STATUS_RESET;
      speed_feedback_word  <= `SPEED_RESET;
      stage_enable         <= 1'b0;
    end
    else
    begin
      // reg_write and reg_wdata deliberately do not reach either word
      inverter_status_word <= status_now;
      stage_enable         <= enabled_now;
      if (speed_done)
        speed_feedback_word <= speed_code;
    end
  end

  // ********************************
  // register port
  // ********************************
  // single read path for all sources; a write is acknowledged but dropped
  always @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata <= 16'h0000;
      reg_ack   <= 1'b0;
    end
    else
    begin
      reg_ack <= reg_read | reg_write;
      if (reg_read)
        reg_rdata <= (reg_sel == `REG_SEL_SPEED) ? speed_feedback_word : inverter_status_word;
    end
  end

  wire unused_wdata = ^reg_wdata;

endmodule // drive_status_speed_feedback

// file: design/speed_scaler.v
// converts an unsigned actual frequency and direction into the signed 8192-scale code
// assumes rated frequency nonzero; result valid one cycle after a start pulse
`timescale 1ns/10ps
`include "drive_status_regs.vh"

module speed_scaler
#(
  parameter FREQ_W = 16
)
(
  // clock and reset
  input  wire              clk,
  input  wire              rst,
  // operands
  input  wire              start,
  input  wire [FREQ_W-1:0] freq,
  input  wire [FREQ_W-1:0] rated,
  input  wire              reverse,
  // result
  output reg               done,
  output reg  [15:0]       code
);

  // ********************************
  // scaling
  // ********************************
  // quotient of freq*8192/rated, truncated toward zero on magnitude
  wire [FREQ_W+12:0] num  = {freq, 13'h0000};
  wire [FREQ_W+12:0] quot = (rated == {FREQ_W{1'b0}}) ? {(FREQ_W+13){1'b1}}
                            : num / {13'h0000, rated};
  // positive side stops at 32767, negative side at -32768
  wire               pos_sat = |quot[FREQ_W+12:15];
  // exactly 32768 still fits as -32768, anything above it does not
  wire               neg_sat = pos_sat | (quot[15] & (|quot[14:0]));
  wire [15:0]        mag     = quot[15:0];
  reg  [15:0]        next_code;

  always @*
  begin
    if (!reverse)
      next_code = pos_sat | quot[15] ? `SPEED_POS_LIMIT : mag;
    else if (neg_sat)
      next_code = `SPEED_NEG_LIMIT;
    else
      next_code = 16'h0000 - mag;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      code <= `SPEED_RESET;
      done <= 1'b0;
    end
    else
    begin
      done <= start;
      if (start)
        code <= next_code;
    end
  end

endmodule // speed_scaler

// file: design/status_packer.v
// packs the inverter state flags into the 16-bit status word
// assumes all flags are synchronous to clk
`timescale 1ns/10ps
`include "drive_status_regs.vh"

module status_packer
(
  // flags
  input  wire        run_request,
  input  wire        override_active,
  input  wire        second_ramp_select,
  input  wire        config_lock,
  input  wire        alarm,
  input  wire        running,
  input  wire        enabled,
  input  wire        forward,
  input  wire        inching_function,
  input  wire        remote,
  input  wire        undervoltage,
  input  wire        fault,
  // word
  output reg  [15:0] word
);

  always @*
  begin
    word                        = 16'h0000;
    word[`STAT_RUN_CMD]         = run_request;
    word[`STAT_OVERRIDE]        = override_active;
    word[`STAT_SECOND_RAMP]     = second_ramp_select;
    word[`STAT_CONFIG_LOCK]     = config_lock;
    word[`STAT_ALARM]           = alarm;
    word[`STAT_RUNNING]         = running;
    word[`STAT_ENABLED]         = enabled;
    word[`STAT_FORWARD]         = forward;
    word[`STAT_INCHING]         = inching_function;
    word[`STAT_REMOTE]          = remote;
    word[`STAT_UNDERVOLT]       = undervoltage;
    word[`STAT_FAULT]           = fault;
  end

endmodule // status_packer
